// *** rtl/rsc_pkg.sv ***
// Package of constants and types for the reset source controller.
package rsc_pkg;
    // ==========================================================
    // Register reset values
    localparam logic [3:0] WCTL_RST = 4'hF;
    localparam logic [7:0] PORT_RST = 8'hFF;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] PC_RST = 8'h00;
    localparam int SP_W = 3;
    localparam logic [2:0] SP_TOP = 3'h0;
    // ==========================================================
    // Timing
    localparam int CLK_NS = 100;
    localparam int LOWV_MIN_NS = 1000;
    localparam int LOWV_CYC = (LOWV_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_STAGES = 3;
    // ==========================================================
    // Reset kinds and sequencer states
    typedef enum logic [2:0] {
        RK_NONE = 3'h0,
        RK_POR = 3'h1,
        RK_FULL = 3'h2,
        RK_WDT_RUN = 3'h3,
        RK_WDT_SLEEP = 3'h4
    } rsc_kind_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HOLD = 2'h1,
        ST_APPLY = 2'h2
    } rsc_state_t;
endpackage

// *** rtl/rsc_sync.sv ***
// Reset request synchroniser: asynchronous assert, three-stage release.
`timescale 1ns/1ps
module rsc_sync (
    input wire logic clk,
    input wire logic req,
    output logic req_sync
);
    import rsc_pkg::*;
    logic [SYNC_STAGES-1:0] sh_r;
    // ==========================================================
    // Assertion is immediate so a request needs no clock edge to act.
    always_ff @(posedge clk or posedge req) begin // R17
        if (req) begin
            sh_r <= '1;
        end else begin
            sh_r <= {sh_r[SYNC_STAGES-2:0], 1'b0};
        end
    end
    assign req_sync = sh_r[SYNC_STAGES-1];
endmodule // rsc_sync

// *** rtl/rsc_lvfilt.sv ***
// Low-supply glitch filter: passes only indications longer than a minimum.
`timescale 1ns/1ps
module rsc_lvfilt #(
    parameter int MIN_CYC = rsc_pkg::LOWV_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic low_in,
    output logic qualified
);
    import rsc_pkg::*;
    logic [15:0] cnt_r;
    logic q_r;
    // ==========================================================
    // Short dips reset the count and never reach the output.
    always_ff @(posedge clk) begin // R04
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            q_r <= 1'b0;
        end else if (ce) begin
            if (!low_in) begin
                cnt_r <= 16'h0000;
                q_r <= 1'b0;
            end else if (cnt_r >= 16'(MIN_CYC)) begin
                q_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end
    assign qualified = q_r;
endmodule // rsc_lvfilt

// *** rtl/rsc_ctrl.sv ***
// Top of the reset source controller: merges sources, sets flags, reloads state.
// What this block does
// R01: A low level on the external reset pin resets the device.
// R02: Every reset clears the program counter to zero.
// R03: Low-voltage reset is enabled only by a static configuration strap.
// R04: Low-supply indications shorter than the minimum duration are ignored.
// R05: Watchdog overflow while running does a full reset and sets timeout flag.
// R06: Watchdog overflow asleep clears PC and stack, sets both flags only.
// R07: Power-on clears both flags; pin or low-voltage reset keeps them.
// R08: Both flags live in status, updated by reset, sleep entry and watchdog.
// R09: Power-on reset disables all interrupts.
// R10: Reset clears the watchdog counter, full resets also the time base counter; watchdog restarts at once.
// R11: Power-on reset switches the timer/event counter off.
// R12: Full resets load port direction and data bits with all ones; sleep watchdog keeps them.
// R13: Reset points the stack pointer at the top of the stack.
// R14: Full resets reload watchdog control and pull-ups; sleep watchdog keeps them.
// R15: Watchdog counter clears on clear-watchdog, halt, pin reset, enable low.
// R16: The pin reset acts only when the static option selects it.
// R17: Power-on and pin reset requests assert asynchronously and release synchronised to the clock.
// R18: Power-on wins over full reset; sleep watchdog only when alone.
`timescale 1ns/1ps
module rsc_ctrl #(
    parameter int LOWV_MIN_CYC = rsc_pkg::LOWV_CYC
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic POR_REQ,
    input wire logic EXT_RESET_N_PIN,
    input wire logic EXT_RESET_OPT,
    input wire logic LOW_SUPPLY_IN,
    input wire logic LOW_SUPPLY_RESET_OPT,
    input wire logic WDT_OVERFLOW,
    input wire logic SLEEP_MODE,
    input wire logic HALT_EXEC,
    input wire logic CLR_WDT_EXEC,
    input wire logic WATCHDOG_ENABLE_BIT,
    output logic CORE_RESET,
    output logic WATCHDOG_TIMEOUT_FLAG,
    output logic POWER_DOWN_FLAG,
    output logic [7:0] PROGRAM_COUNTER_LOW,
    output logic PC_LOAD,
    output logic [rsc_pkg::SP_W-1:0] STACK_PTR,
    output logic SP_LOAD,
    output logic PERIPH_RELOAD,
    output logic [3:0] WATCHDOG_CONTROL_REG,
    output logic [7:0] PORT_A_DIRECTION,
    output logic [7:0] PORT_A_DATA,
    output logic [7:0] PORT_A_PULLUP_ENABLE,
    output logic INT_DISABLE,
    output logic TIMER_OFF,
    output logic ACCUMULATOR_UNDEF,
    output logic WDT_CLEAR,
    output logic TIMEBASE_CLEAR
);
    import rsc_pkg::*;
    // ==========================================================
    // Source qualification
    logic pin_req_async;
    logic por_sync;
    logic pin_sync;
    logic lv_raw_sync;
    logic lv_s1_r;
    logic lv_s2_r;
    logic lv_s3_r;
    logic lv_qual;
    logic lv_req;
    logic wdt_run;
    logic wdt_sleep;
    logic full_any;
    rsc_kind_t kind_nxt;
    rsc_kind_t kind_r;
    rsc_state_t st_r;
    rsc_state_t st_nxt;
    logic wdt_prev_r;
    logic wdt_edge;
    logic sleep_r;
    logic to_r;
    logic pdf_r;
    logic pin_seen_r;

    assign pin_req_async = EXT_RESET_OPT & ~EXT_RESET_N_PIN; // R01 R16

    rsc_sync u_por_sync (
        .clk(MCLK),
        .req(POR_REQ),
        .req_sync(por_sync)
    );
    rsc_sync u_pin_sync (
        .clk(MCLK),
        .req(pin_req_async),
        .req_sync(pin_sync)
    ); // R17

    // The supply monitor output is a plain level from outside the domain.
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            lv_s1_r <= 1'b0;
            lv_s2_r <= 1'b0;
            lv_s3_r <= 1'b0;
        end else if (CE) begin
            lv_s1_r <= LOW_SUPPLY_IN;
            lv_s2_r <= lv_s1_r;
            lv_s3_r <= lv_s2_r;
        end
    end
    assign lv_raw_sync = lv_s2_r & lv_s3_r;

    rsc_lvfilt #(.MIN_CYC(LOWV_MIN_CYC)) u_lvfilt (
        .clk(MCLK),
        .rst_n(RESET_N),
        .ce(CE),
        .low_in(lv_raw_sync),
        .qualified(lv_qual)
    ); // R04
    assign lv_req = lv_qual & LOW_SUPPLY_RESET_OPT; // R03

    assign wdt_edge = WDT_OVERFLOW & ~wdt_prev_r;
    assign wdt_run = wdt_edge & ~SLEEP_MODE; // R05
    assign wdt_sleep = wdt_edge & SLEEP_MODE; // R06
    assign full_any = pin_sync | lv_req | wdt_run;

    // ==========================================================
    // Priority of simultaneous sources
    always_comb begin // R18
        if (por_sync) begin
            kind_nxt = RK_POR;
        end else if (pin_sync | lv_req) begin
            kind_nxt = RK_FULL;
        end else if (wdt_run) begin
            kind_nxt = RK_WDT_RUN;
        end else if (wdt_sleep) begin
            kind_nxt = RK_WDT_SLEEP;
        end else begin
            kind_nxt = RK_NONE;
        end
    end

    // ==========================================================
    // Sequencer: hold while a source is active, then apply once on release.
    always_comb begin
        case (st_r)
            ST_IDLE: st_nxt = (kind_nxt != RK_NONE) ? ST_HOLD : ST_IDLE;
            ST_HOLD: st_nxt = (por_sync | pin_sync | lv_req) ? ST_HOLD : ST_APPLY;
            ST_APPLY: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            st_r <= ST_IDLE;
            kind_r <= RK_POR;
            wdt_prev_r <= 1'b0;
            sleep_r <= 1'b0;
            pin_seen_r <= 1'b0;
        end else if (CE) begin
            st_r <= st_nxt;
            wdt_prev_r <= WDT_OVERFLOW;
            sleep_r <= SLEEP_MODE;
            if (st_r == ST_IDLE) begin
                kind_r <= kind_nxt;
                pin_seen_r <= pin_sync;
            end else if (kind_nxt != RK_NONE && kind_nxt < kind_r) begin
                kind_r <= kind_nxt; // R18
                pin_seen_r <= pin_seen_r | pin_sync;
            end else begin
                pin_seen_r <= pin_seen_r | pin_sync;
            end
        end
    end

    // ==========================================================
    // Status flags. Power-on clears; sleep watchdog sets both; running
    // watchdog sets timeout only; sleep entry sets power-down and clears timeout.
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            to_r <= 1'b0;
            pdf_r <= 1'b0;
        end else if (CE) begin
            if (kind_r == RK_POR && st_r != ST_IDLE) begin
                to_r <= 1'b0; // R07
                pdf_r <= 1'b0; // R07
            end else if (wdt_sleep && !full_any && !por_sync) begin
                to_r <= 1'b1; // R06
                pdf_r <= 1'b1; // R06
            end else if (wdt_run) begin
                to_r <= 1'b1; // R05
            end else if (SLEEP_MODE && !sleep_r) begin
                to_r <= 1'b0; // R08
                pdf_r <= 1'b1; // R08
            end
        end
    end
    assign WATCHDOG_TIMEOUT_FLAG = to_r;
    assign POWER_DOWN_FLAG = pdf_r;

    // ==========================================================
    // Reload strobes and default values
    logic apply;
    logic full_apply;
    assign apply = (st_r == ST_APPLY);
    assign full_apply = apply & (kind_r != RK_WDT_SLEEP);
    assign CORE_RESET = (st_r == ST_HOLD) | por_sync | pin_sync | lv_req;
    assign PC_LOAD = apply; // R02
    assign SP_LOAD = apply; // R13
    assign PERIPH_RELOAD = full_apply; // R14 R12
    assign INT_DISABLE = full_apply; // R09
    assign TIMER_OFF = full_apply; // R11
    assign ACCUMULATOR_UNDEF = apply & pin_seen_r; // R14
    assign TIMEBASE_CLEAR = full_apply; // R10
    // Watchdog clears on reset end so it counts again at the next cycle.
    assign WDT_CLEAR = apply | CLR_WDT_EXEC | (SLEEP_MODE & ~sleep_r) | HALT_EXEC
        | pin_sync | ~WATCHDOG_ENABLE_BIT; // R10 R15

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            PROGRAM_COUNTER_LOW <= PC_RST;
            STACK_PTR <= SP_TOP;
            WATCHDOG_CONTROL_REG <= WCTL_RST;
            PORT_A_DIRECTION <= PORT_RST;
            PORT_A_DATA <= PORT_RST;
            PORT_A_PULLUP_ENABLE <= PULLUP_RST;
        end else if (CE && full_apply) begin
            PROGRAM_COUNTER_LOW <= PC_RST; // R02
            STACK_PTR <= SP_TOP; // R13
            WATCHDOG_CONTROL_REG <= WCTL_RST; // R14
            PORT_A_DIRECTION <= PORT_RST; // R12
            PORT_A_DATA <= PORT_RST; // R12
            PORT_A_PULLUP_ENABLE <= PULLUP_RST; // R14
        end else if (CE && apply) begin
            PROGRAM_COUNTER_LOW <= PC_RST; // R06
            STACK_PTR <= SP_TOP; // R06
        end
    end
endmodule // rsc_ctrl

// *** dv/rsc_ctrl_props.sv ***
// Concurrent checks on the ports of the reset source controller.
`timescale 1ns/1ps
module rsc_ctrl_props
    import rsc_pkg::*;
(
    input wire logic MCLK, RESET_N, CE, EXT_RESET_N_PIN, EXT_RESET_OPT, POR_REQ,
    input wire logic WDT_OVERFLOW, SLEEP_MODE, HALT_EXEC, CLR_WDT_EXEC, WATCHDOG_ENABLE_BIT,
    input wire logic CORE_RESET, WATCHDOG_TIMEOUT_FLAG, POWER_DOWN_FLAG, PC_LOAD, SP_LOAD,
    input wire logic PERIPH_RELOAD, WDT_CLEAR, TIMEBASE_CLEAR,
    input wire logic [7:0] PROGRAM_COUNTER_LOW, PORT_A_DIRECTION, PORT_A_DATA,
    input wire logic [7:0] PORT_A_PULLUP_ENABLE,
    input wire logic [rsc_pkg::SP_W-1:0] STACK_PTR,
    input wire logic [3:0] WATCHDOG_CONTROL_REG
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // Watchdog cases are judged only when no stronger source is in play.
    wire quiet = !POR_REQ && !CORE_RESET && CE;
    sequence s_sleep_apply;
        WATCHDOG_TIMEOUT_FLAG && POWER_DOWN_FLAG && PC_LOAD && SP_LOAD && !PERIPH_RELOAD;
    endsequence
    sequence s_run_apply;
        WATCHDOG_TIMEOUT_FLAG && PERIPH_RELOAD && PC_LOAD;
    endsequence
    property p_pc; PC_LOAD |=> PROGRAM_COUNTER_LOW == PC_RST; endproperty
    property p_sp; SP_LOAD |=> STACK_PTR == SP_TOP; endproperty
    property p_ext; $fell(EXT_RESET_N_PIN) && EXT_RESET_OPT |-> ##[0:4] CORE_RESET; endproperty
    property p_run; $rose(WDT_OVERFLOW) && !SLEEP_MODE && quiet |-> ##[1:3] s_run_apply;
    endproperty
    property p_sleep; $rose(WDT_OVERFLOW) && SLEEP_MODE && quiet |-> ##[1:3] s_sleep_apply;
    endproperty
    property p_reload;
        PERIPH_RELOAD |=> WATCHDOG_CONTROL_REG == WCTL_RST && PORT_A_PULLUP_ENABLE == PULLUP_RST;
    endproperty
    property p_ports;
        PERIPH_RELOAD |=> PORT_A_DIRECTION == PORT_RST && PORT_A_DATA == PORT_RST;
    endproperty
    property p_clr; PERIPH_RELOAD |-> WDT_CLEAR && TIMEBASE_CLEAR; endproperty
    property p_wclr;
        (HALT_EXEC || CLR_WDT_EXEC || !WATCHDOG_ENABLE_BIT) && CE |-> ##[0:1] WDT_CLEAR;
    endproperty
    property p_release; $fell(CORE_RESET) && CE |-> PC_LOAD; endproperty
    a_pc: assert property (p_pc) else $error("pc not cleared");
    a_sp: assert property (p_sp) else $error("stack not at top");
    a_ext: assert property (p_ext) else $error("pin low gave no reset");
    a_run: assert property (p_run) else $error("running timeout wrong");
    a_sleep: assert property (p_sleep) else $error("sleep timeout wrong");
    a_reload: assert property (p_reload) else $error("control defaults wrong");
    a_ports: assert property (p_ports) else $error("port defaults wrong");
    a_clr: assert property (p_clr) else $error("counters not cleared");
    a_wclr: assert property (p_wclr) else $error("watchdog not cleared");
    a_release: assert property (p_release) else $error("release without apply");
endmodule // rsc_ctrl_props
bind rsc_ctrl rsc_ctrl_props u_props (.*);

// *** dv/rsc_far.sv ***
// Model of the reset pin network and the supply monitor.
`timescale 1ns/1ps
module rsc_far (
    input wire logic clk,
    output logic por_req,
    output logic pin_n,
    output logic low_in
);
    initial begin
        por_req = 1'b0;
        pin_n = 1'b1;
        low_in = 1'b0;
    end
    // Source k (0 power-on, 1 pin, 2 supply dip) is held active for n cycles.
    // The pin has a pull-up, so it returns high once the network lets go.
    task automatic drive(input int k, input int n);
        @(posedge clk);
        por_req <= (k == 0);
        pin_n <= (k != 1);
        low_in <= (k == 2);
        repeat (n) @(posedge clk);
        por_req <= 1'b0;
        pin_n <= 1'b1;
        low_in <= 1'b0;
    endtask
endmodule // rsc_far

// *** dv/tb_top.sv ***
// Self-checking bench for the reset source controller.
`timescale 1ns/1ps
module tb_top;
    import rsc_pkg::*;
    logic mclk = 0, reset_n = 0, ce = 1, ext_opt = 1, lv_opt = 1, wdt_ov = 0;
    logic sleep = 0, halt = 0, clrw = 0, wen = 1;
    logic por_req, pin_n, low_in, core_rst, to_f, pd_f, pc_ld, sp_ld, rld;
    logic int_dis, tmr_off, acc_u, wclr, tbclr;
    logic [7:0] pc, dir, dat, pu;
    logic [SP_W-1:0] sp;
    logic [3:0] watchdog_control_reg;
    int n_mismatch = 0, compares = 0;
    int seen [0:5];
    always #50 mclk = ~mclk;
    rsc_far far (.clk(mclk), .por_req(por_req), .pin_n(pin_n), .low_in(low_in));
    rsc_ctrl #(.LOWV_MIN_CYC(4)) DUT (
        .MCLK(mclk), .RESET_N(reset_n), .CE(ce), .POR_REQ(por_req),
        .EXT_RESET_N_PIN(pin_n), .EXT_RESET_OPT(ext_opt), .LOW_SUPPLY_IN(low_in),
        .LOW_SUPPLY_RESET_OPT(lv_opt), .WDT_OVERFLOW(wdt_ov), .SLEEP_MODE(sleep),
        .HALT_EXEC(halt), .CLR_WDT_EXEC(clrw), .WATCHDOG_ENABLE_BIT(wen),
        .CORE_RESET(core_rst), .WATCHDOG_TIMEOUT_FLAG(to_f), .POWER_DOWN_FLAG(pd_f),
        .PROGRAM_COUNTER_LOW(pc), .PC_LOAD(pc_ld), .STACK_PTR(sp), .SP_LOAD(sp_ld),
        .PERIPH_RELOAD(rld), .WATCHDOG_CONTROL_REG(watchdog_control_reg), .PORT_A_DIRECTION(dir),
        .PORT_A_DATA(dat), .PORT_A_PULLUP_ENABLE(pu), .INT_DISABLE(int_dis),
        .TIMER_OFF(tmr_off), .ACCUMULATOR_UNDEF(acc_u), .WDT_CLEAR(wclr),
        .TIMEBASE_CLEAR(tbclr)
    );
    // Counts of cycles each watched output is high since the last clear, seen[3] summing int_dis and tmr_off; cleared on the falling edge to avoid races.
    always @(posedge mclk) begin
        seen[0] += (core_rst === 1'b1);
        seen[1] += (rld === 1'b1);
        seen[2] += (acc_u === 1'b1);
        seen[3] += (int_dis === 1'b1) + (tmr_off === 1'b1);
        seen[4] += (pc_ld === 1'b1);
        seen[5] += (wclr === 1'b1);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic clr();
        @(negedge mclk) seen = '{default: 0};
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic overflow();
        clr();
        @(posedge mclk) wdt_ov <= 1'b1;
        @(posedge mclk) wdt_ov <= 1'b0;
        idle(12);
    endtask
    task automatic t_wdt_run();
        overflow();
        chk({to_f, pd_f}, 8'h02);
        chk(seen[1], 1);
        chk(seen[4], 1);
        chk(seen[5] != 0, 1);
        chk({watchdog_control_reg, 4'h0}, {WCTL_RST, 4'h0});
        chk(pu, PULLUP_RST);
        chk(dir & dat, PORT_RST);
        chk({pc[7:3], sp}, 8'h00);
        $display("watchdog running test done");
    endtask
    task automatic t_sleep();
        @(posedge mclk) sleep <= 1'b1;
        idle(3);
        chk({to_f, pd_f}, 8'h01);
        overflow();
        chk({to_f, pd_f}, 8'h03);
        chk(seen[1], 0);
        chk(seen[4], 1);
        @(posedge mclk) sleep <= 1'b0;
        $display("watchdog sleep test done");
    endtask
    task automatic t_pin();
        @(posedge mclk) ext_opt <= 1'b0;
        clr();
        far.drive(1, 6);
        idle(12);
        chk(seen[0], 0);
        @(posedge mclk) ext_opt <= 1'b1;
        clr();
        far.drive(1, 6);
        idle(12);
        chk(seen[0] != 0, 1);
        chk(seen[2], 1);
        chk({to_f, pd_f}, 8'h03);
        $display("pin test done");
    endtask
    task automatic t_supply();
        @(posedge mclk) lv_opt <= 1'b0;
        clr();
        far.drive(2, 20);
        idle(12);
        chk(seen[0], 0);
        @(posedge mclk) lv_opt <= 1'b1;
        clr();
        far.drive(2, 2);
        idle(12);
        chk(seen[0], 0);
        far.drive(2, 12);
        idle(12);
        chk(seen[0] != 0, 1);
        chk({to_f, pd_f}, 8'h03);
        $display("supply test done");
    endtask
    task automatic t_por();
        clr();
        // A running watchdog overflow inside the power-on hold must not set the flag.
        fork
            far.drive(0, 5);
            begin
                idle(2);
                @(posedge mclk) wdt_ov <= 1'b1;
                @(posedge mclk) wdt_ov <= 1'b0;
            end
        join
        idle(12);
        chk({to_f, pd_f}, 8'h00);
        chk(seen[3], 2);
        chk(seen[4], 1);
        clr();
        @(posedge mclk) halt <= 1'b1;
        @(posedge mclk) halt <= 1'b0;
        clrw <= 1'b1;
        @(posedge mclk) clrw <= 1'b0;
        wen <= 1'b0;
        @(posedge mclk) wen <= 1'b1;
        idle(2);
        chk(seen[5] >= 3, 1);
        $display("power-on test done");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        idle(20);
        reset_n <= 1'b1;
        idle(2);
        t_wdt_run();
        t_sleep();
        t_pin();
        t_supply();
        t_por();
        tally_and_finish();
    end
    // The tests need a few hundred cycles; this limit is far beyond that.
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // tb_top
